// >>> tbmc_pkg.sv
// Purpose: Shared constants and types for the tape block mark codec.
// Assumes: 40 MHz system clock; head signals and host strobes are asynchronous.
// Notes: Mark codes other than the data code are local choices held here once.

package tbmc_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ = 40_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	// Nominal bit rate of the timing track
	localparam int BIT_RATE_HZ = 25_000;
	localparam int BIT_CYC = CLK_HZ / BIT_RATE_HZ;
	// Two missing bit cells mean the tape has stalled
	localparam int LOSS_CYC = 2 * BIT_CYC;
	localparam logic [11:0] LOSS_LAST = 12'(LOSS_CYC - 1);
	// Ready indications stand this long unless a transfer clears them
	localparam int READY_US = 40;
	localparam int READY_CYC = READY_US * CYC_PER_US;
	localparam logic [10:0] READY_LAST = 11'(READY_CYC - 1);

	// ==========================================================
	// Word layout
	localparam int WORD_W = 16;
	localparam int GRP_W = 6;
	localparam int TRACKS = 3;
	localparam int HIGH_USED = 4;
	localparam int KIND_W = 2;
	localparam int ENTRY_W = KIND_W + WORD_W;
	localparam int BUF_DEPTH = 2;
	localparam logic [1:0] BUF_FULL = 2'h2;

	// ==========================================================
	// Mark track codes, six bits as seen in the mark shift register
	localparam logic [5:0] MARK_DATA = 6'h21;
	localparam logic [5:0] MARK_CKSUM = 6'h2a;
	localparam logic [5:0] MARK_BLK_FWD = 6'h15;
	localparam logic [5:0] MARK_BLK_END = 6'h0b;
	localparam logic [5:0] MARK_BLK_REV = 6'h34;
	localparam logic [5:0] MARK_FIN_DATA = 6'h10;
	localparam logic [5:0] MARK_FIN_CKSUM = 6'h18;

	// ==========================================================
	// Tape format
	localparam logic [8:0] WORDS_PER_BLOCK = 9'h100;
	localparam logic [15:0] TRAILER_FIRST = 16'h0190;
	localparam logic [15:0] TRAILER_LAST = 16'h0197;

	// Synchroniser reset image: active-low host strobes idle high
	localparam int SYNC_W = 26;
	localparam logic [25:0] SYNC_RST = 26'h0000007;

	typedef enum logic [1:0] {
		KIND_NONE = 2'h0,
		KIND_BLOCK = 2'h1,
		KIND_DATA = 2'h2,
		KIND_CKSUM = 2'h3
	} tbmc_kind_t;

	typedef enum logic [1:0] {
		REGION_PRELIM = 2'h0,
		REGION_DATA = 2'h1,
		REGION_TRAILER = 2'h2,
		REGION_OTHER = 2'h3
	} tbmc_region_t;

	typedef enum logic [2:0] {
		WR_OFF = 3'h1,
		WR_ARMED = 3'h2,
		WR_SHIFT = 3'h4
	} tbmc_wr_state_t;

endpackage

// >>> tbmc_stream_if.sv
// Purpose: Valid/ready word stream between the codec and its buffer.
// Assumes: One clock domain; data is stable while valid and not ready.
// Notes: Entry holds kind in the top bits and the word below.
`timescale 1ns/1ps

interface tbmc_stream_if;
	logic valid;
	logic ready;
	logic [tbmc_pkg::ENTRY_W-1:0] data;
	modport sink(input valid, input data, output ready);
	modport source(output valid, output data, input ready);
endinterface

// >>> tbmc_buf2.sv
// Purpose: Two-entry word buffer with valid and ready on both sides.
// Assumes: Push and pop may happen in the same cycle.
// Notes: Full and empty follow the occupancy count exactly.
`timescale 1ns/1ps

module tbmc_buf2 (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	tbmc_stream_if.sink s_in,
	tbmc_stream_if.source s_out
);
	logic [tbmc_pkg::ENTRY_W-1:0] mem_reg [0:tbmc_pkg::BUF_DEPTH-1];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	wire push = s_in.valid & s_in.ready;
	wire pop = s_out.valid & s_out.ready;

	// ==========================================================
	// Flags and occupancy
	assign s_in.ready = (cnt_reg != tbmc_pkg::BUF_FULL);
	assign s_out.valid = (cnt_reg != 2'h0);
	assign s_out.data = mem_reg[rd_ptr_reg];
	assign cnt_next = (push & ~pop) ? cnt_reg + 2'h1 : (pop & ~push) ? cnt_reg - 2'h1 : cnt_reg;

	// Storage is cleared at reset so the head never shows stale words
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < tbmc_pkg::BUF_DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (push) begin
			mem_reg[wr_ptr_reg] <= s_in.data;
		end
	end

	// Pointers wrap naturally at depth two
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg ^ push;
			rd_ptr_reg <= rd_ptr_reg ^ pop;
			cnt_reg <= cnt_next;
		end
	end
endmodule

// >>> tbmc_codec.sv
// Purpose: Mark decode, serial shifting and word framing for block-marked tape.
// Assumes: Head and host signals are asynchronous; host bus is stable around its strobe.
// Notes: Host strobes and ready lines are active low; host data buses and the tape side are positive true.
// How it works
// - Word is six characters over three data tracks.
// - Checksum is 16-bit wrapping sum of data.
// - Leading block number forward, trailing only reverse.
// - Tracks carry low, middle, high six-bit groups.
// - Timing track edges strobe mark and data.
// - Shift four registers serially at bit rate.
// - Mark code 41 octal flags data ready.
// - Distinct marks flag checksum and block numbers.
// - On data ready, load word, shift out.
// - Final mark codes separate write timing.
// - Four hundred blocks of 256 words each.
// - Preliminary blocks carry negative numbers.
// - Trailer blocks 620 to 627 octal follow.
// - Never write timing, mark or block numbers.
// - Host interface lines are active low; here only strobes and ready lines are, the data buses are positive true.
// - Ready lasts 40 us, cleared by transfer.
// - Writers switch off at each block end.
`timescale 1ns/1ps

module tbmc_codec (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_trk_timing,
	input wire logic i_trk_mark,
	input wire logic [2:0] i_trk_data,
	input wire logic i_motion_fwd,
	input wire logic i_motion_rev,
	input wire logic i_in_xfer_n,
	input wire logic i_out_xfer_n,
	input wire logic i_write_on_n,
	input wire logic [15:0] i_out_data,
	output logic [15:0] o_in_data,
	output logic o_block_ready_n,
	output logic o_data_ready_n,
	output logic o_cksum_ready_n,
	output logic o_wr_en,
	output logic [2:0] o_wr_data,
	output logic [1:0] o_blk_region,
	output logic [15:0] o_block_sum,
	output logic o_size_err,
	output logic o_overrun
);

	// ==========================================================
	// Input synchronisers
	logic [tbmc_pkg::SYNC_W-1:0] sync1_reg;
	logic [tbmc_pkg::SYNC_W-1:0] sync2_reg;
	logic [4:0] edge_reg;
	wire [tbmc_pkg::SYNC_W-1:0] async_in;

	// Every pin passes two flops; edge history is taken only from stage two
	assign async_in = {i_out_data, i_trk_timing, i_trk_mark, i_trk_data,
		i_motion_fwd, i_motion_rev, i_in_xfer_n, i_out_xfer_n, i_write_on_n};

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_reg <= tbmc_pkg::SYNC_RST;
			sync2_reg <= tbmc_pkg::SYNC_RST;
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Named views of the second stage
	wire [15:0] out_bus = sync2_reg[25:10];
	wire tim_s = sync2_reg[9];
	wire mark_s = sync2_reg[8];
	wire [2:0] dat_s = sync2_reg[7:5];
	wire fwd_s = sync2_reg[4];
	wire rev_s = sync2_reg[3];
	wire in_xfer_s_n = sync2_reg[2];
	wire out_xfer_s_n = sync2_reg[1];
	wire wr_on_s_n = sync2_reg[0];

	// Previous values for edge detection
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			edge_reg <= 5'h07;
		end else begin
			edge_reg <= {tim_s, 1'b0, in_xfer_s_n, out_xfer_s_n, wr_on_s_n};
		end
	end

	// Strobe decode; host lines are ground true so a falling edge is a command
	wire tim_rise = tim_s & ~edge_reg[4];
	wire tim_fall = ~tim_s & edge_reg[4];
	wire in_xfer = ~in_xfer_s_n & edge_reg[2];
	wire out_xfer = ~out_xfer_s_n & edge_reg[1];
	wire wr_on_cmd = ~wr_on_s_n & edge_reg[0];
	wire any_xfer = in_xfer | out_xfer;

	// ==========================================================
	// Motion tracking and stall detection
	logic [1:0] dir_reg;
	logic [11:0] idle_reg;
	wire fwd = fwd_s & ~rev_s;
	wire rev = rev_s & ~fwd_s;
	wire moving = fwd | rev;
	wire [1:0] dir_now = {fwd, rev};
	// Any change of direction, stop included, invalidates partial patterns
	wire dir_change = (dir_now != dir_reg);
	wire tape_lost = (idle_reg == tbmc_pkg::LOSS_LAST);
	wire flush = dir_change | tape_lost;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dir_reg <= 2'h0;
			idle_reg <= 12'h000;
		end else begin
			dir_reg <= dir_now;
			idle_reg <= (tim_rise | tim_fall | tape_lost) ? 12'h000 : idle_reg + 12'h001;
		end
	end

	// ==========================================================
	// Read shift registers: one mark plus three data tracks
	logic [5:0] mark_sr_reg;
	logic [5:0] dat_sr_reg [0:tbmc_pkg::TRACKS-1];
	logic shift_done_reg;
	wire sample = tim_rise & moving;

	// Forward bits enter at the bottom; reverse bits enter at the top so codes keep one orientation
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mark_sr_reg <= 6'h00;
			shift_done_reg <= 1'b0;
		end else begin
			shift_done_reg <= sample & ~flush;
			if (flush) begin
				mark_sr_reg <= 6'h00;
			end else if (sample) begin
				mark_sr_reg <= fwd ? {mark_sr_reg[4:0], mark_s} : {mark_s, mark_sr_reg[5:1]};
			end
		end
	end

	genvar t;
	generate
		for (t = 0; t < tbmc_pkg::TRACKS; t++) begin : g_rd_track
			// Each data track collects one six-bit group per word
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					dat_sr_reg[t] <= 6'h00;
				end else if (flush) begin
					dat_sr_reg[t] <= 6'h00;
				end else if (sample) begin
					dat_sr_reg[t] <= fwd ? {dat_sr_reg[t][4:0], dat_s[t]} : {dat_s[t], dat_sr_reg[t][5:1]};
				end
			end
		end
	endgenerate

	// Low, middle and high groups; the top two bits of the high group are dropped
	wire [15:0] rd_word = {dat_sr_reg[2][tbmc_pkg::HIGH_USED-1:0], dat_sr_reg[1], dat_sr_reg[0]};

	// ==========================================================
	// Mark decoder
	wire mark_hit = shift_done_reg;
	wire dec_data = mark_hit & (mark_sr_reg == tbmc_pkg::MARK_DATA);
	wire dec_cksum = mark_hit & (mark_sr_reg == tbmc_pkg::MARK_CKSUM);
	// The leading number is decoded forward only, the trailing one in reverse only
	wire dec_blk_fwd = mark_hit & fwd & (mark_sr_reg == tbmc_pkg::MARK_BLK_FWD);
	wire dec_blk_rev = mark_hit & rev & (mark_sr_reg == tbmc_pkg::MARK_BLK_REV);
	wire dec_blk_end = mark_hit & fwd & (mark_sr_reg == tbmc_pkg::MARK_BLK_END);
	wire dec_fin = mark_hit & ((mark_sr_reg == tbmc_pkg::MARK_FIN_DATA) |
		(mark_sr_reg == tbmc_pkg::MARK_FIN_CKSUM));
	wire dec_block = dec_blk_fwd | dec_blk_rev;
	wire dec_word = dec_data | dec_cksum | dec_block;

	// Entry kind for the host's ready lines
	wire [1:0] dec_kind = dec_block ? tbmc_pkg::KIND_BLOCK : dec_data ? tbmc_pkg::KIND_DATA :
		dec_cksum ? tbmc_pkg::KIND_CKSUM : tbmc_pkg::KIND_NONE;

	// ==========================================================
	// Word buffer toward the host
	tbmc_stream_if buf_in ();
	tbmc_stream_if buf_out ();

	tbmc_buf2 u_buf (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.s_in(buf_in.sink),
		.s_out(buf_out.source)
	);

	// A full buffer means the host missed two words; that word is dropped and flagged
	assign buf_in.valid = dec_word;
	assign buf_in.data = {dec_kind, rd_word};

	// ==========================================================
	// Presentation register and ready lines
	logic pres_valid_reg;
	logic [1:0] pres_kind_reg;
	logic [15:0] pres_data_reg;
	logic [10:0] age_reg;
	logic overrun_reg;
	wire expire = pres_valid_reg & (age_reg == tbmc_pkg::READY_LAST);
	wire pres_clear = pres_valid_reg & (any_xfer | expire);
	assign buf_out.ready = ~pres_valid_reg;
	wire pres_load = buf_out.valid & ~pres_valid_reg;

	// Word stays still in the register for as long as its ready line stands
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pres_valid_reg <= 1'b0;
			pres_kind_reg <= tbmc_pkg::KIND_NONE;
			pres_data_reg <= 16'h0000;
			age_reg <= 11'h000;
		end else if (pres_load) begin
			pres_valid_reg <= 1'b1;
			pres_kind_reg <= buf_out.data[tbmc_pkg::ENTRY_W-1:tbmc_pkg::WORD_W];
			pres_data_reg <= buf_out.data[tbmc_pkg::WORD_W-1:0];
			age_reg <= 11'h000;
		end else if (pres_clear) begin
			pres_valid_reg <= 1'b0;
			age_reg <= 11'h000;
		end else if (pres_valid_reg) begin
			age_reg <= age_reg + 11'h001;
		end
	end

	// Overrun pulse when a decoded word finds the buffer full
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			overrun_reg <= 1'b0;
		end else begin
			overrun_reg <= dec_word & ~buf_in.ready;
		end
	end

	// Ground-true ready lines toward the host
	assign o_block_ready_n = ~(pres_valid_reg & (pres_kind_reg == tbmc_pkg::KIND_BLOCK));
	assign o_data_ready_n = ~(pres_valid_reg & (pres_kind_reg == tbmc_pkg::KIND_DATA));
	assign o_cksum_ready_n = ~(pres_valid_reg & (pres_kind_reg == tbmc_pkg::KIND_CKSUM));
	assign o_in_data = pres_data_reg;
	assign o_overrun = overrun_reg;

	// ==========================================================
	// Write holding register, filled by the host's output transfer
	logic [15:0] wr_hold_reg;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_hold_reg <= 16'h0000;
		end else if (out_xfer) begin
			wr_hold_reg <= out_bus;
		end
	end

	// ==========================================================
	// Writer control
	tbmc_pkg::tbmc_wr_state_t wr_state_reg;
	tbmc_pkg::tbmc_wr_state_t wr_state_next;
	// Only data and checksum marks open a write, so pre-marked fields are never touched
	wire wr_load = (wr_state_reg == tbmc_pkg::WR_ARMED) & (dec_data | dec_cksum);
	// Writers are refused in reverse; the host must respect the enable window
	wire wr_arm = wr_on_cmd & fwd;

	always_comb begin
		wr_state_next = wr_state_reg;
		unique case (wr_state_reg)
			tbmc_pkg::WR_OFF: begin
				if (wr_arm) begin
					wr_state_next = tbmc_pkg::WR_ARMED;
				end
			end
			tbmc_pkg::WR_ARMED: begin
				if (wr_load) begin
					wr_state_next = tbmc_pkg::WR_SHIFT;
				end
			end
			tbmc_pkg::WR_SHIFT: begin
				if (dec_fin) begin
					wr_state_next = tbmc_pkg::WR_ARMED;
				end
			end
			default: begin
				wr_state_next = tbmc_pkg::WR_OFF;
			end
		endcase
		// Block end, stop or reversal turn the writers off whatever the state
		if (dec_blk_end | flush) begin
			wr_state_next = tbmc_pkg::WR_OFF;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_state_reg <= tbmc_pkg::WR_OFF;
		end else begin
			wr_state_reg <= wr_state_next;
		end
	end

	// ==========================================================
	// Write shift registers, one per data track
	logic [5:0] wsr_reg [0:tbmc_pkg::TRACKS-1];
	logic [2:0] wr_data_reg;
	logic wr_en_reg;
	wire [17:0] wr_image = {2'h0, wr_hold_reg};
	wire wr_shift = tim_fall & (wr_state_reg == tbmc_pkg::WR_SHIFT);

	generate
		for (t = 0; t < tbmc_pkg::TRACKS; t++) begin : g_wr_track
			// Bits change on the falling timing edge, half a cell from the read strobe
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					wsr_reg[t] <= 6'h00;
					wr_data_reg[t] <= 1'b0;
				end else if (wr_load) begin
					wsr_reg[t] <= wr_image[t*tbmc_pkg::GRP_W +: tbmc_pkg::GRP_W];
				end else if (wr_shift) begin
					wr_data_reg[t] <= wsr_reg[t][5];
					wsr_reg[t] <= {wsr_reg[t][4:0], 1'b0};
				end
			end
		end
	endgenerate

	// Writer enable follows the shift state only
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_en_reg <= 1'b0;
		end else begin
			wr_en_reg <= (wr_state_next == tbmc_pkg::WR_SHIFT);
		end
	end

	assign o_wr_en = wr_en_reg;
	assign o_wr_data = wr_data_reg;

	// ==========================================================
	// Per-block bookkeeping
	logic [8:0] word_cnt_reg;
	logic [15:0] sum_reg;
	logic size_err_reg;
	logic [1:0] region_reg;
	// While writing, the sum follows the words going out, else the words read
	wire [15:0] acc_word = (wr_state_reg == tbmc_pkg::WR_ARMED) ? wr_hold_reg : rd_word;
	// Negative numbers lead, then data blocks, then the trailer range
	wire [1:0] region_now = rd_word[15] ? tbmc_pkg::REGION_PRELIM :
		(rd_word < tbmc_pkg::TRAILER_FIRST) ? tbmc_pkg::REGION_DATA :
		(rd_word <= tbmc_pkg::TRAILER_LAST) ? tbmc_pkg::REGION_TRAILER :
		tbmc_pkg::REGION_OTHER;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			word_cnt_reg <= 9'h000;
			sum_reg <= 16'h0000;
			size_err_reg <= 1'b0;
			region_reg <= tbmc_pkg::REGION_OTHER;
		end else if (dec_block) begin
			word_cnt_reg <= 9'h000;
			sum_reg <= 16'h0000;
			size_err_reg <= 1'b0;
			region_reg <= region_now;
		end else if (dec_data) begin
			word_cnt_reg <= word_cnt_reg + 9'h001;
			sum_reg <= sum_reg + acc_word;
		end else if (dec_cksum) begin
			size_err_reg <= (word_cnt_reg != tbmc_pkg::WORDS_PER_BLOCK);
		end
	end

	assign o_blk_region = region_reg;
	assign o_block_sum = sum_reg;
	assign o_size_err = size_err_reg;

endmodule

// >>> tbmc_codec_sva.sv
// Purpose: Port-level checks on the tape block mark codec.
// Assumes: One clock domain; reset asynchronous and active low.
// Notes: A presented word is taken to drop its ready line for a cycle before the next one.
`timescale 1ns/1ps

module tbmc_codec_sva (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_motion_fwd,
	input wire logic i_motion_rev,
	input wire logic i_in_xfer_n,
	input wire logic i_out_xfer_n,
	input wire logic [15:0] o_in_data,
	input wire logic o_block_ready_n,
	input wire logic o_data_ready_n,
	input wire logic o_cksum_ready_n,
	input wire logic o_wr_en,
	input wire logic [1:0] o_blk_region,
	input wire logic o_overrun
);
	// ==========================================================
	// Helper decode
	wire any_rdy = !(o_block_ready_n && o_data_ready_n && o_cksum_ready_n);
	wire in_trailer = (o_in_data >= tbmc_pkg::TRAILER_FIRST) && (o_in_data <= tbmc_pkg::TRAILER_LAST);
	wire [1:0] region_exp = o_in_data[15] ? 2'h0 :
		(o_in_data < tbmc_pkg::TRAILER_FIRST) ? 2'h1 : in_trailer ? 2'h2 : 2'h3;
	logic [11:0] span_reg;

	// Length of one presentation; counter, because a repetition that long would choke the tools
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			span_reg <= 12'h000;
		end else begin
			span_reg <= any_rdy ? span_reg + 12'h001 : 12'h000;
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	// ==========================================================
	// Assertions
	chk_one_ready: assert property ($onehot0({!o_block_ready_n, !o_data_ready_n, !o_cksum_ready_n}))
		else $error("more than one ready line low");
	chk_xfer_clears: assert property (($fell(i_in_xfer_n) || $fell(i_out_xfer_n)) && any_rdy
		|-> ##[1:5] !any_rdy)
		else $error("transfer did not clear ready");
	chk_ready_holds: assert property ($fell(o_data_ready_n) && i_in_xfer_n && i_out_xfer_n |=> !o_data_ready_n [*2])
		else $error("data ready dropped too early");
	chk_ready_span: assert property (span_reg <= 12'(tbmc_pkg::READY_CYC + 2))
		else $error("ready stood past its limit");
	chk_word_stands: assert property (any_rdy && $past(any_rdy) |-> $stable(o_in_data))
		else $error("presented word changed while ready");
	chk_region_class: assert property (!o_block_ready_n |-> o_blk_region == region_exp)
		else $error("block region does not match block number");
	chk_wr_motion: assert property ((!i_motion_fwd || i_motion_rev) [*6] |-> !o_wr_en)
		else $error("writers on without forward motion");
	chk_overrun_pulse: assert property (o_overrun |=> !o_overrun)
		else $error("overrun longer than one cycle");
	chk_reset_idle: assert property ($rose(i_rst_n) |-> !any_rdy && !o_wr_en && o_blk_region == 2'h3)
		else $error("outputs not idle after reset");
endmodule

bind tbmc_codec tbmc_codec_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_motion_fwd(i_motion_fwd),
	.i_motion_rev(i_motion_rev), .i_in_xfer_n(i_in_xfer_n), .i_out_xfer_n(i_out_xfer_n), .o_in_data(o_in_data),
	.o_block_ready_n(o_block_ready_n), .o_data_ready_n(o_data_ready_n), .o_cksum_ready_n(o_cksum_ready_n),
	.o_wr_en(o_wr_en), .o_blk_region(o_blk_region), .o_overrun(o_overrun));

// >>> tbmc_tape_model.sv
// Purpose: Behavioural tape heads feeding timing, mark and data tracks.
// Assumes: Timing runs free at 200 ns per cell while the bench runs.
// Notes: Columns are queued by tasks; idle cells carry no mark and toggling data.
`timescale 1ns/1ps

module tbmc_tape_model (
	output logic o_trk_timing,
	output logic o_trk_mark,
	output logic [2:0] o_trk_data
);
	logic [3:0] col_q[$];
	logic [3:0] col;

	// ==========================================================
	// Queue one word: first cell is the MSB forward, the LSB in reverse
	task automatic push(input logic rev, input logic [5:0] mark, input logic [15:0] word);
		logic [17:0] g;
		int b;
		g = {2'h0, word};
		for (int i = 0; i < 6; i++) begin
			b = rev ? i : 5 - i;
			col_q.push_back({mark[b], g[12+b], g[6+b], g[b]});
		end
	endtask

	// Mark ones keep sliding windows away from other codes
	task automatic ones(input int n);
		repeat (n) col_q.push_back(4'h8);
	endtask

	// Tracks change mid-way through the low phase, so timing edges strobe settled bits
	initial begin
		o_trk_timing = 1'b0;
		o_trk_mark = 1'b0;
		o_trk_data = 3'h0;
		#3.3;
		forever begin
			#50;
			col = (col_q.size() != 0) ? col_q.pop_front() : {1'b0, ~o_trk_data};
			o_trk_mark = col[3];
			o_trk_data = col[2:0];
			#50 o_trk_timing = 1'b1;
			#100 o_trk_timing = 1'b0;
		end
	end
endmodule

// >>> tbmc_codec_test.sv
// Purpose: Self-checking bench for the tape block mark codec.
// Assumes: Host strobes idle high; tape model drives the heads.
// Notes: Each scenario is its own task and judges its own results.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
	end \
end

module tbmc_codec_test;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_motion_fwd = 1'b1;
	logic i_motion_rev = 1'b0;
	logic i_in_xfer_n = 1'b1;
	logic i_out_xfer_n = 1'b1;
	logic i_write_on_n = 1'b1;
	logic [15:0] i_out_data = 16'h0000;
	logic trk_timing;
	logic trk_mark;
	logic [2:0] trk_data;
	logic [15:0] o_in_data;
	logic [15:0] o_block_sum;
	logic o_block_ready_n, o_data_ready_n, o_cksum_ready_n, o_wr_en, o_size_err, o_overrun;
	logic [2:0] o_wr_data;
	logic [1:0] o_blk_region;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	logic seen_ovr = 1'b0;
	wire [2:0] rdy = {~o_block_ready_n, ~o_data_ready_n, ~o_cksum_ready_n};

	// ==========================================================
	// Clock, tape and design
	always #12.5 i_clk_sys = ~i_clk_sys;

	tbmc_tape_model u_tape (.o_trk_timing(trk_timing), .o_trk_mark(trk_mark), .o_trk_data(trk_data));

	tbmc_codec DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_trk_timing(trk_timing), .i_trk_mark(trk_mark),
		.i_trk_data(trk_data), .i_motion_fwd(i_motion_fwd), .i_motion_rev(i_motion_rev), .i_in_xfer_n(i_in_xfer_n),
		.i_out_xfer_n(i_out_xfer_n), .i_write_on_n(i_write_on_n), .i_out_data(i_out_data), .o_in_data(o_in_data),
		.o_block_ready_n(o_block_ready_n), .o_data_ready_n(o_data_ready_n), .o_cksum_ready_n(o_cksum_ready_n),
		.o_wr_en(o_wr_en), .o_wr_data(o_wr_data), .o_blk_region(o_blk_region), .o_block_sum(o_block_sum),
		.o_size_err(o_size_err), .o_overrun(o_overrun));

	// Sticky overrun flag, so its one-cycle pulse is never missed; also the hang guard
	always @(posedge i_clk_sys) begin
		cyc++;
		if (o_overrun === 1'b1) seen_ovr <= 1'b1;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic wait_kind(input logic [2:0] exp, input int lim);
		int n;
		n = 0;
		while (rdy === 3'h0 && n < lim) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		`CHK("ready kind", exp, rdy)
	endtask

	// Strobe held four clocks so the synchroniser sees it; data set well before
	task automatic xfer(input logic out);
		@(posedge i_clk_sys);
		if (out) i_out_xfer_n <= 1'b0;
		else i_in_xfer_n <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		i_out_xfer_n <= 1'b1;
		i_in_xfer_n <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		#1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_block_read;
		logic [15:0] w[2];
		logic [15:0] sum;
		w = '{16'hf00d, 16'h2345};
		sum = 16'h0000;
		u_tape.push(1'b0, tbmc_pkg::MARK_BLK_FWD, 16'h0190);
		u_tape.ones(5);
		wait_kind(3'h4, 400);
		`CHK("block word", 16'h0190, o_in_data)
		`CHK("block region", 2'h2, o_blk_region)
		xfer(1'b0);
		for (int i = 0; i < 2; i++) begin
			u_tape.push(1'b0, tbmc_pkg::MARK_DATA, w[i]);
			wait_kind(3'h2, 400);
			`CHK("data word", w[i], o_in_data)
			sum = sum + w[i];
			xfer(1'b0);
		end
		u_tape.ones(6);
		u_tape.push(1'b0, tbmc_pkg::MARK_CKSUM, sum);
		wait_kind(3'h1, 400);
		`CHK("checksum word", sum, o_in_data)
		`CHK("block sum", 16'h1352, o_block_sum)
		`CHK("short block", 1'b1, o_size_err)
		xfer(1'b0);
	endtask

	task automatic t_refuse;
		u_tape.push(1'b0, tbmc_pkg::MARK_BLK_REV, 16'h0055);
		wait_kind(3'h0, 150);
	endtask

	task automatic t_overrun;
		for (int i = 0; i < 4; i++) u_tape.push(1'b0, tbmc_pkg::MARK_DATA, 16'h1000 + 16'(i));
		repeat (240) @(posedge i_clk_sys);
		#1;
		`CHK("overrun seen", 1'b1, seen_ovr)
		for (int i = 0; i < 3; i++) begin
			`CHK("buffered ready", 3'h2, rdy)
			`CHK("buffered word", 16'h1000 + 16'(i), o_in_data)
			xfer(1'b0);
		end
		wait_kind(3'h0, 50);
	endtask

	task automatic t_expiry;
		int n;
		u_tape.push(1'b0, tbmc_pkg::MARK_DATA, 16'h0bad);
		wait_kind(3'h2, 400);
		n = 0;
		while (rdy !== 3'h0 && n < 2000) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		`CHK("ready lifetime", 1'b1, (n >= 1595 && n <= 1605))
	endtask

	task automatic t_reverse;
		@(posedge i_clk_sys);
		i_motion_fwd <= 1'b0;
		i_motion_rev <= 1'b1;
		repeat (8) @(posedge i_clk_sys);
		u_tape.push(1'b1, tbmc_pkg::MARK_BLK_REV, 16'hfff9);
		wait_kind(3'h4, 400);
		`CHK("trailing number", 16'hfff9, o_in_data)
		`CHK("prelim region", 2'h0, o_blk_region)
		xfer(1'b0);
		i_motion_fwd <= 1'b1;
		i_motion_rev <= 1'b0;
		repeat (8) @(posedge i_clk_sys);
	endtask

	task automatic t_write;
		logic [17:0] g;
		int n;
		logic wr_seen;
		g = {2'h0, 16'h9a5c};
		n = 0;
		u_tape.push(1'b0, tbmc_pkg::MARK_BLK_FWD, 16'h0007);
		u_tape.ones(5);
		wait_kind(3'h4, 400);
		xfer(1'b0);
		@(posedge i_clk_sys);
		i_write_on_n <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		i_write_on_n <= 1'b1;
		i_out_data <= 16'h9a5c;
		repeat (4) @(posedge i_clk_sys);
		xfer(1'b1);
		u_tape.push(1'b0, tbmc_pkg::MARK_DATA, 16'h0000);
		while (o_wr_en !== 1'b1 && n < 200) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		`CHK("writers on", 1'b1, o_wr_en)
		for (int k = 5; k >= 4; k--) begin
			@(posedge trk_timing);
			repeat (2) @(posedge i_clk_sys);
			#1;
			`CHK("write bits", {g[12+k], g[6+k], g[k]}, o_wr_data)
		end
		repeat (160) @(posedge i_clk_sys);
		#1;
		`CHK("final mark stop", 1'b0, o_wr_en)
		xfer(1'b0);
		u_tape.push(1'b0, tbmc_pkg::MARK_BLK_END, 16'h0007);
		repeat (100) @(posedge i_clk_sys);
		#1;
		wr_seen = 1'b0;
		u_tape.push(1'b0, tbmc_pkg::MARK_DATA, 16'h0000);
		repeat (120) begin
			@(posedge i_clk_sys);
			#1;
			wr_seen = wr_seen | o_wr_en;
		end
		`CHK("writers off after block", 1'b0, wr_seen)
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		#1;
		`CHK("reset ready", 3'h0, rdy)
		`CHK("reset region", 2'h3, o_blk_region)
		t_block_read();
		t_refuse();
		t_overrun();
		t_expiry();
		t_reverse();
		t_write();
		give_verdict();
	end
endmodule
